// ### slcr_pkg.sv
// Purpose: Constants and carriers for the serial lane configuration bank
// Assumes: Wishbone classic slave, 32-bit data, byte addresses = 4 x index
// Notes:
// Operation
// RULE1: Loss flag asserts after filter count high cycles
// RULE2: Termination bit connects or removes termination
// RULE3: Detector enable switches loss detector on
// RULE4: Receive invert flips all twenty word bits
// RULE5: Software starts equalization at code 010
// RULE6: Transmit reset bit holds transmitter, active high
// RULE7: Rate field divides baud clock 1,2,4
// RULE8: Transmit enable turns transmitter on
// RULE9: Data enable passes or blocks transmit data
// RULE10: Common mode enable drives common mode voltage
// RULE11: Termination offset and amplitude reach driver
// RULE12: Boost enable gates boost, level selects
// RULE13: Transmit invert sends data inverted
// RULE14: Software holds detect request until acknowledge
// RULE15: Pre-emphasis field value reaches driver
// RULE16: Reserved bits read zero, ignore writes
package slcr_pkg;
   // --------------------------------------------------------------
   // Register indices and byte address width
   // --------------------------------------------------------------
   localparam logic [15:0] SLCR_IDX_RX_B = 16'hD004;
   localparam logic [15:0] SLCR_IDX_TX_A = 16'hD005;
   localparam logic [15:0] SLCR_IDX_TX_B = 16'hD006;
   localparam logic [15:0] SLCR_IDX_TX_C = 16'hD007;
   localparam logic [15:0] SLCR_IDX_IRQ_ST = 16'hD00E;
   localparam logic [15:0] SLCR_IDX_IRQ_MSK = 16'hD00F;
   localparam logic [15:0] SLCR_IDX_LANE_ST = 16'hD010;
   localparam int SLCR_AW = 18;
   // --------------------------------------------------------------
   // Write masks and reset values
   // --------------------------------------------------------------
   localparam logic [15:0] SLCR_MASK_RX_B = 16'h1FFF;
   localparam logic [15:0] SLCR_MASK_TX_A = 16'h003F;
   localparam logic [15:0] SLCR_MASK_TX_B = 16'h0FFF;
   localparam logic [15:0] SLCR_MASK_TX_C = 16'h1FFF;
   localparam logic [15:0] SLCR_MASK_IRQ = 16'h0003;
   localparam logic [15:0] SLCR_RST_RX_B = 16'h0000;
   localparam logic [15:0] SLCR_RST_TX_A = 16'h0000;
   localparam logic [15:0] SLCR_RST_TX_B = 16'h0000;
   localparam logic [15:0] SLCR_RST_TX_C = 16'h0800;
   localparam logic [15:0] SLCR_RST_ZERO = 16'h0000;
   // Transmit rate codes
   localparam logic [1:0] SLCR_RATE_DIV1 = 2'h0;
   localparam logic [1:0] SLCR_RATE_DIV2 = 2'h1;
   localparam logic [1:0] SLCR_RATE_DIV4 = 2'h2;
   localparam logic [1:0] SLCR_RATE_RES = 2'h3;
   localparam int SLCR_WORD_W = 20;
   localparam int SLCR_CNT_W = 7;
   // --------------------------------------------------------------
   // Field carriers
   // --------------------------------------------------------------
   typedef struct packed {
      logic [2:0] pad;
      logic [6:0] signal_loss_filter_count;
      logic receive_termination_enable;
      logic signal_loss_detector_enable;
      logic receive_polarity_flip;
      logic [2:0] receive_equalization;
   } slcr_rx_b_t;
   typedef struct packed {
      logic [9:0] pad;
      logic transmitter_reset;
      logic [1:0] transmit_rate_divider;
      logic transmitter_enable;
      logic transmit_data_enable;
      logic transmit_common_mode_enable;
   } slcr_tx_a_t;
   typedef struct packed {
      logic [3:0] pad;
      logic [4:0] transmit_termination_offset;
      logic [6:0] transmit_amplitude;
   } slcr_tx_b_t;
   typedef struct packed {
      logic [2:0] pad;
      logic transmit_boost_enable;
      logic [2:0] transmit_boost_level;
      logic transmit_polarity_flip;
      logic far_receiver_detect_request;
      logic [6:0] transmit_pre_emphasis;
   } slcr_tx_c_t;
   typedef struct packed {
      logic [4:0] transmit_termination_offset;
      logic [6:0] transmit_amplitude;
      logic [6:0] transmit_pre_emphasis;
      logic transmit_boost_active;
      logic [2:0] transmit_boost_level;
      logic transmit_common_mode_enable;
      logic receive_termination_enable;
      logic [2:0] receive_equalization;
   } slcr_analog_t;
endpackage : slcr_pkg

// ### slcr_loss_filter.sv
// Purpose: Qualifies raw signal loss over a programmed cycle count
// Assumes: raw_loss_i already synchronised to clk_i
// Notes: A count of zero asserts on the first high cycle
module slcr_loss_filter
   import slcr_pkg::*;
#(
   parameter int CNT_W = SLCR_CNT_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic raw_loss_i,
   input wire logic [CNT_W-1:0] count_i,
   output logic loss_o
);
   logic [CNT_W-1:0] run_q;
   logic [CNT_W-1:0] run_d;
   logic loss_q;
   wire logic active = enable_i & raw_loss_i;
   wire logic reached = (run_q >= count_i);
   // Saturate so long losses never wrap back to clear
   assign run_d = (!active) ? '0 : (reached ? run_q : run_q + 1'b1);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= '0;
         loss_q <= 1'b0;
      end else begin
         run_q <= run_d;
         loss_q <= active & reached; // [RULE1] [RULE3]
      end
   end
   assign loss_o = loss_q;
endmodule : slcr_loss_filter

// ### slcr_rate_div.sv
// Purpose: Baud enable pulse at divide by 1, 2 or 4
// Assumes: Baud rate sampled as an enable on clk_i
// Notes: Reserved code gives no pulses
module slcr_rate_div
   import slcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hold_i,
   input wire logic [1:0] rate_i,
   output logic tick_o
);
   logic [1:0] cnt_q;
   logic tick_q;
   wire logic hit = (rate_i == SLCR_RATE_DIV1) ||
                    (rate_i == SLCR_RATE_DIV2 && cnt_q[0]) ||
                    (rate_i == SLCR_RATE_DIV4 && cnt_q == 2'h3);
   always_ff @(posedge clk_i) begin
      if (rst_i || hold_i) begin
         cnt_q <= 2'h0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         tick_q <= hit; // [RULE7]
      end
   end
   assign tick_o = tick_q;
endmodule : slcr_rate_div

// ### slcr_lane_regs.sv
// Purpose: Lane configuration register bank over Wishbone classic
// Assumes: Single clock clk_i, synchronous reset rst_i
// Notes: Ack one cycle after strobe; hardware may update rwh fields
module slcr_lane_regs
   import slcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [SLCR_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Lane side
   input wire logic raw_signal_loss_i,
   input wire logic receive_detect_ack_i,
   input wire logic hw_tx_update_i,
   input wire logic [5:0] hw_tx_value_i,
   input wire logic [SLCR_WORD_W-1:0] receive_parallel_word_i,
   output logic [SLCR_WORD_W-1:0] receive_parallel_word_o,
   input wire logic [SLCR_WORD_W-1:0] transmit_word_i,
   output logic [SLCR_WORD_W-1:0] transmit_word_o,
   output logic transmit_word_valid_o,
   output logic filtered_signal_loss_flag_o,
   output logic signal_loss_detector_enable_o,
   output logic transmitter_reset_o,
   output logic transmitter_enable_o,
   output logic far_receiver_detect_request_o,
   output slcr_analog_t analog_o,
   output logic irq_o
);
   // ----------
   // Registers
   // ----------
   slcr_rx_b_t rx_b_q;
   slcr_tx_a_t tx_a_q;
   slcr_tx_b_t tx_b_q;
   slcr_tx_c_t tx_c_q;
   logic [15:0] irq_st_q;
   logic [15:0] irq_msk_q;
   logic ack_q;
   logic err_q;
   logic [31:0] rdat_q;
   logic loss_s1_q;
   logic loss_s2_q;
   logic dack_s1_q;
   logic dack_s2_q;
   logic dack_prev_q;
   logic loss_prev_q;
   logic [SLCR_WORD_W-1:0] rx_word_q;
   logic [SLCR_WORD_W-1:0] tx_word_q;
   logic tx_valid_q;
   logic loss_flag;
   logic baud_tick;

   // ----------
   // Address decode
   // ----------
   wire logic req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
   wire logic [15:0] idx = wb_adr_i[SLCR_AW-1:2];
   wire logic hit_rx_b = (idx == SLCR_IDX_RX_B);
   wire logic hit_tx_a = (idx == SLCR_IDX_TX_A);
   wire logic hit_tx_b = (idx == SLCR_IDX_TX_B);
   wire logic hit_tx_c = (idx == SLCR_IDX_TX_C);
   wire logic hit_ist = (idx == SLCR_IDX_IRQ_ST);
   wire logic hit_imsk = (idx == SLCR_IDX_IRQ_MSK);
   wire logic hit_lst = (idx == SLCR_IDX_LANE_ST);
   wire logic mapped = hit_rx_b | hit_tx_a | hit_tx_b | hit_tx_c |
                       hit_ist | hit_imsk | hit_lst;
   wire logic wr = req & wb_we_i & mapped;
   // Registers are 16 bits wide; only low two byte lanes matter
   wire logic [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire logic [15:0] wmask = lane_mask;

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [15:0] new_v,
                                         input logic [15:0] lanes,
                                         input logic [15:0] keep);
      merge = ((old_v & ~lanes) | (new_v & lanes)) & keep;
   endfunction : merge

   wire logic [15:0] rx_b_wr = merge(rx_b_q, wb_dat_i[15:0], wmask, SLCR_MASK_RX_B);
   wire logic [15:0] tx_a_wr = merge(tx_a_q, wb_dat_i[15:0], wmask, SLCR_MASK_TX_A);
   wire logic [15:0] tx_b_wr = merge(tx_b_q, wb_dat_i[15:0], wmask, SLCR_MASK_TX_B);
   wire logic [15:0] tx_c_wr = merge(tx_c_q, wb_dat_i[15:0], wmask, SLCR_MASK_TX_C);
   wire logic [15:0] msk_wr = merge(irq_msk_q, wb_dat_i[15:0], wmask, SLCR_MASK_IRQ);

   // Reserved bits are masked in storage so they always read zero [RULE16]
   wire logic [15:0] lane_status = {14'h0000, dack_s2_q, loss_flag};
   wire logic [15:0] rsel = hit_rx_b ? rx_b_q :
                            hit_tx_a ? tx_a_q :
                            hit_tx_b ? tx_b_q :
                            hit_tx_c ? tx_c_q :
                            hit_ist ? irq_st_q :
                            hit_imsk ? irq_msk_q :
                            hit_lst ? lane_status : SLCR_RST_ZERO;

   // ----------
   // Events and interrupt
   // ----------
   wire logic ev_loss = loss_flag & ~loss_prev_q;
   wire logic ev_dack = dack_s2_q & ~dack_prev_q;
   wire logic [15:0] ev_vec = {14'h0000, ev_dack, ev_loss};
   wire logic [15:0] ist_clr = (wr & hit_ist) ? (wb_dat_i[15:0] & wmask) : SLCR_RST_ZERO;
   // Set wins over a simultaneous write-one clear
   wire logic [15:0] ist_d = ((irq_st_q & ~ist_clr) | ev_vec) & SLCR_MASK_IRQ;

   // ----------
   // Register update
   // ----------
   // Hardware update of rwh transmit fields yields to a software write
   wire logic [15:0] tx_a_hw = {10'h000, hw_tx_value_i} & SLCR_MASK_TX_A;
   wire logic [15:0] tx_a_d = (wr & hit_tx_a) ? tx_a_wr :
                              hw_tx_update_i ? tx_a_hw : tx_a_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_b_q <= SLCR_RST_RX_B;
         tx_a_q <= SLCR_RST_TX_A;
         tx_b_q <= SLCR_RST_TX_B;
         tx_c_q <= SLCR_RST_TX_C;
         irq_msk_q <= SLCR_RST_ZERO;
         irq_st_q <= SLCR_RST_ZERO;
      end else begin
         if (wr & hit_rx_b) rx_b_q <= rx_b_wr; // [RULE16]
         tx_a_q <= tx_a_d;
         if (wr & hit_tx_b) tx_b_q <= tx_b_wr;
         if (wr & hit_tx_c) tx_c_q <= tx_c_wr;
         if (wr & hit_imsk) irq_msk_q <= msk_wr;
         irq_st_q <= ist_d;
      end
   end

   // ----------
   // Bus answer
   // ----------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & mapped;
         err_q <= req & ~mapped;
         rdat_q <= (req & mapped) ? {16'h0000, rsel} : 32'h0000_0000;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
   assign wb_dat_o = rdat_q;

   // ----------
   // Pin synchronisers
   // ----------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_s1_q <= 1'b0;
         loss_s2_q <= 1'b0;
         dack_s1_q <= 1'b0;
         dack_s2_q <= 1'b0;
         dack_prev_q <= 1'b0;
         loss_prev_q <= 1'b0;
      end else begin
         loss_s1_q <= raw_signal_loss_i;
         loss_s2_q <= loss_s1_q;
         dack_s1_q <= receive_detect_ack_i;
         dack_s2_q <= dack_s1_q;
         dack_prev_q <= dack_s2_q;
         loss_prev_q <= loss_flag;
      end
   end

   slcr_loss_filter #(
      .CNT_W(SLCR_CNT_W)
   ) u_loss (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(rx_b_q.signal_loss_detector_enable), // [RULE3]
      .raw_loss_i(loss_s2_q),
      .count_i(rx_b_q.signal_loss_filter_count), // [RULE1]
      .loss_o(loss_flag)
   );

   slcr_rate_div u_rate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hold_i(tx_a_q.transmitter_reset),
      .rate_i(tx_a_q.transmit_rate_divider), // [RULE7]
      .tick_o(baud_tick)
   );

   // ----------
   // Data paths
   // ----------
   wire logic tx_run = tx_a_q.transmitter_enable & ~tx_a_q.transmitter_reset; // [RULE6] [RULE8]
   wire logic tx_pass = tx_run & tx_a_q.transmit_data_enable; // [RULE9]
   wire logic [SLCR_WORD_W-1:0] tx_flip = {SLCR_WORD_W{tx_c_q.transmit_polarity_flip}};
   wire logic [SLCR_WORD_W-1:0] rx_flip = {SLCR_WORD_W{rx_b_q.receive_polarity_flip}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_word_q <= '0;
         tx_word_q <= '0;
         tx_valid_q <= 1'b0;
      end else begin
         rx_word_q <= receive_parallel_word_i ^ rx_flip; // [RULE4]
         tx_valid_q <= tx_pass & baud_tick;
         if (tx_a_q.transmitter_reset) begin
            tx_word_q <= '0; // [RULE6]
         end else if (tx_pass & baud_tick) begin
            tx_word_q <= transmit_word_i ^ tx_flip; // [RULE13] [RULE9]
         end
      end
   end
   assign receive_parallel_word_o = rx_word_q;
   assign transmit_word_o = tx_word_q;
   assign transmit_word_valid_o = tx_valid_q;

   // ----------
   // Outputs to analog
   // ----------
   assign analog_o.transmit_termination_offset = tx_b_q.transmit_termination_offset; // [RULE11]
   assign analog_o.transmit_amplitude = tx_b_q.transmit_amplitude; // [RULE11]
   assign analog_o.transmit_pre_emphasis = tx_c_q.transmit_pre_emphasis; // [RULE15]
   assign analog_o.transmit_boost_active = tx_c_q.transmit_boost_enable & tx_run; // [RULE12]
   assign analog_o.transmit_boost_level = tx_c_q.transmit_boost_level; // [RULE12]
   assign analog_o.transmit_common_mode_enable = tx_a_q.transmit_common_mode_enable; // [RULE10]
   assign analog_o.receive_termination_enable = rx_b_q.receive_termination_enable; // [RULE2]
   // Reset value leaves software to load the 010 start point
   assign analog_o.receive_equalization = rx_b_q.receive_equalization; // [RULE5]
   assign filtered_signal_loss_flag_o = loss_flag;
   assign signal_loss_detector_enable_o = rx_b_q.signal_loss_detector_enable;
   assign transmitter_reset_o = tx_a_q.transmitter_reset; // [RULE6]
   assign transmitter_enable_o = tx_run; // [RULE8]
   // Request only forwarded; software holds it until acknowledge [RULE14]
   assign far_receiver_detect_request_o = tx_c_q.far_receiver_detect_request;
   assign irq_o = |(irq_st_q & irq_msk_q);
endmodule : slcr_lane_regs

// ### slcr_lane_partner.sv
// Purpose: Far end model: signal loss, detect acknowledge, receive words
// Assumes: Same clock as the bank, synchronous active high reset
// Notes: Slow mode stretches the acknowledge wait to sixteen cycles
module slcr_lane_partner
   import slcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic detect_req_i,
   input wire logic slow_i,
   input wire logic loss_i,
   output logic detect_ack_o,
   output logic raw_loss_o,
   output logic [SLCR_WORD_W-1:0] word_o
);
   // ----------
   // Line behaviour
   // ----------
   logic [3:0] wait_q;
   always_ff @(posedge clk_i) begin
      raw_loss_o <= loss_i;
      // Word moves every cycle out of reset so a stale value never passes
      word_o <= word_o + 20'h3C3C5;
      if (rst_i) begin
         wait_q <= 4'h0;
         detect_ack_o <= 1'b0;
         word_o <= 20'h5A5A5;
      end else if (!detect_req_i) begin
         wait_q <= 4'h0;
         detect_ack_o <= 1'b0;
      end else if (wait_q == (slow_i ? 4'hF : 4'h2)) begin
         detect_ack_o <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule : slcr_lane_partner

// ### slcr_lane_props.sv
// Purpose: Port level checks on the lane configuration bank
// Assumes: One clock, synchronous active high reset
// Notes: Bound from the bench top file
module slcr_lane_props
   import slcr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [SLCR_AW-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic raw_signal_loss_i,
   input wire logic [SLCR_WORD_W-1:0] receive_parallel_word_i,
   input wire logic [SLCR_WORD_W-1:0] receive_parallel_word_o,
   input wire logic [SLCR_WORD_W-1:0] transmit_word_o,
   input wire logic transmit_word_valid_o,
   input wire logic filtered_signal_loss_flag_o,
   input wire logic signal_loss_detector_enable_o,
   input wire logic transmitter_reset_o,
   input wire logic transmitter_enable_o,
   input wire slcr_analog_t analog_o
);
   // ----------
   // Bus cycle and field checks
   // ----------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence taken_s;
      $rose(wb_stb_i) && wb_cyc_i;
   endsequence
   sequence answer_s;
      (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
   endsequence
   bus_answer_a:
      assert property (taken_s |=> answer_s) else $error("bus answer late or long");
   bus_excl_a:
      assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err together");
   idle_data_a:
      assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("data off ack");
   rsvd_zero_a:
      assert property (wb_ack_o && !wb_we_i && wb_adr_i[17:2] == SLCR_IDX_TX_A
         |-> wb_dat_o[31:6] == 26'h0000000) else $error("reserved bits read set");
   rx_flip_a:
      assert property (!$past(rst_i) |-> (receive_parallel_word_o ^
         $past(receive_parallel_word_i)) inside {20'h00000, 20'hFFFFF})
         else $error("receive word partly flipped");
   loss_off_a:
      assert property ((!signal_loss_detector_enable_o)[*2] |-> !filtered_signal_loss_flag_o)
         else $error("loss flag with detector off");
   loss_cause_a:
      assert property ($rose(filtered_signal_loss_flag_o) |-> signal_loss_detector_enable_o
         && $past(raw_signal_loss_i, 3)) else $error("loss flag without raw loss");
   tx_off_a:
      assert property (transmitter_reset_o |-> !transmitter_enable_o)
         else $error("transmitter runs in reset");
   tx_quiet_a:
      assert property (transmitter_reset_o[*2] |-> !transmit_word_valid_o
         && transmit_word_o == 20'h00000) else $error("transmit data in reset");
   boost_gate_a:
      assert property (analog_o.transmit_boost_active |-> transmitter_enable_o
         || $past(transmitter_enable_o)) else $error("boost while transmitter off");
endmodule : slcr_lane_props

// ### slcr_lane_regs_tb.sv
// Purpose: Self-checking bench for the lane configuration bank
// Assumes: Wishbone classic master, ack or err ends every cycle
// Notes: Partner model drives loss, detect acknowledge and receive words
module slcr_lane_regs_tb
   import slcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------
   // Signals and instances
   // ----------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, upd = 1'b0, loss_cmd = 1'b0, slow = 1'b0;
   logic [SLCR_AW-1:0] adr = '0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h00000000, rdat;
   logic [5:0] upd_v = 6'h00;
   logic [19:0] txw = 20'h00000, rxw_i, rxw_o, txw_o;
   logic ack, err, txv, loss_f, det_en, tx_rst, tx_en, det_req, irq, raw, det_ack;
   slcr_analog_t ana;
   int n_mismatch = 0;
   int check_count = 0;
   logic [15:0] idx_t [4] = '{SLCR_IDX_RX_B, SLCR_IDX_TX_A, SLCR_IDX_TX_B, SLCR_IDX_TX_C};
   logic [15:0] rst_t [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0800};
   logic [15:0] msk_t [4] = '{16'h1FFF, 16'h003F, 16'h0FFF, 16'h1FFF};
   always #12.5 clk_i = ~clk_i;
   slcr_lane_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .raw_signal_loss_i(raw), .receive_detect_ack_i(det_ack),
      .hw_tx_update_i(upd), .hw_tx_value_i(upd_v), .receive_parallel_word_i(rxw_i),
      .receive_parallel_word_o(rxw_o), .transmit_word_i(txw), .transmit_word_o(txw_o),
      .transmit_word_valid_o(txv), .filtered_signal_loss_flag_o(loss_f),
      .signal_loss_detector_enable_o(det_en), .transmitter_reset_o(tx_rst),
      .transmitter_enable_o(tx_en), .far_receiver_detect_request_o(det_req),
      .analog_o(ana), .irq_o(irq));
   slcr_lane_partner u_far (.clk_i(clk_i), .rst_i(rst_i), .detect_req_i(det_req),
      .slow_i(slow), .loss_i(loss_cmd), .detect_ack_o(det_ack), .raw_loss_o(raw),
      .word_o(rxw_i));
   // ----------
   // Bus and check helpers
   // ----------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d,
         output logic [15:0] q, output logic e);
      int n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
      q = rdat[15:0];
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 40) n_mismatch++;
   endtask : wb
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      logic [15:0] q;
      logic e;
      wb(1'b1, idx, d, q, e);
   endtask : wr
   task automatic rdc(input string nm, input logic [15:0] idx, input logic [15:0] exp);
      logic [15:0] q;
      logic e;
      wb(1'b0, idx, 16'h0000, q, e);
      chk(nm, {16'h0000, q}, {16'h0000, exp});
   endtask : rdc
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic ticks(output int n);
      n = 0;
      repeat (4) @(posedge clk_i);
      repeat (16) begin
         @(posedge clk_i);
         #1;
         if (txv === 1'b1) n++;
      end
   endtask : ticks
   // ----------
   // Scenarios
   // ----------
   task automatic t_reset;
      for (int i = 0; i < 4; i++) rdc("reset value", idx_t[i], rst_t[i]);
      rdc("irq status", SLCR_IDX_IRQ_ST, 16'h0000);
      chk("irq idle", {31'h0, irq}, 32'h0);
   endtask : t_reset
   task automatic t_regs;
      logic [15:0] q;
      logic e;
      for (int i = 0; i < 4; i++) begin
         wr(idx_t[i], 16'hFFFF);
         rdc("masked readback", idx_t[i], msk_t[i]);
      end
      chk("term on", {31'h0, ana.receive_termination_enable}, 32'h1);
      chk("offset max", {27'h0, ana.transmit_termination_offset}, 32'h1F);
      chk("pre-emphasis", {25'h0, ana.transmit_pre_emphasis}, 32'h7F);
      chk("boost in reset", {31'h0, ana.transmit_boost_active}, 32'h0);
      wb(1'b1, 16'hD00B, 16'hFFFF, q, e);
      chk("unmapped write", {31'h0, e}, 32'h1);
      wb(1'b0, 16'hD00B, 16'h0000, q, e);
      chk("unmapped read", {31'h0, e}, 32'h1);
      for (int i = 0; i < 4; i++) wr(idx_t[i], 16'h0000);
      wr(SLCR_IDX_TX_B, 16'h0A5A);
      rdc("tx b", SLCR_IDX_TX_B, 16'h0A5A);
      chk("term off", {31'h0, ana.receive_termination_enable}, 32'h0);
      chk("amplitude", {25'h0, ana.transmit_amplitude}, 32'h5A);
      chk("offset", {27'h0, ana.transmit_termination_offset}, 32'h14);
   endtask : t_regs
   task automatic t_rx;
      logic [19:0] w;
      wr(SLCR_IDX_RX_B, 16'h001A);
      for (int i = 0; i < 6; i++) begin
         if (i == 3) wr(SLCR_IDX_RX_B, 16'h0012);
         @(posedge clk_i);
         #1;
         w = rxw_i;
         @(posedge clk_i);
         #1;
         chk("receive word", {12'h0, rxw_o}, {12'h0, (i < 3) ? ~w : w});
      end
   endtask : t_rx
   task automatic t_loss;
      int n;
      wr(SLCR_IDX_IRQ_ST, 16'h0003);
      wr(SLCR_IDX_IRQ_MSK, 16'h0000);
      wr(SLCR_IDX_RX_B, 16'h0152);
      chk("eq start", {29'h0, ana.receive_equalization}, 32'h2);
      chk("det on", {31'h0, det_en}, 32'h1);
      loss_cmd <= 1'b1;
      repeat (5) @(posedge clk_i);
      #1;
      chk("flag early", {31'h0, loss_f}, 32'h0);
      n = 0;
      while (loss_f !== 1'b1 && n < 30) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("flag set", {31'h0, loss_f}, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rdc("loss event", SLCR_IDX_IRQ_ST, 16'h0001);
      wr(SLCR_IDX_IRQ_MSK, 16'h0001);
      settle();
      chk("irq raised", {31'h0, irq}, 32'h1);
      wr(SLCR_IDX_IRQ_ST, 16'h0001);
      settle();
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wr(SLCR_IDX_RX_B, 16'h0142);
      settle();
      chk("detector off", {31'h0, loss_f}, 32'h0);
      chk("det off", {31'h0, det_en}, 32'h0);
      loss_cmd <= 1'b0;
   endtask : t_loss
   task automatic t_tx;
      int n;
      int exp_n [4] = '{16, 8, 4, 0};
      @(posedge clk_i);
      upd <= 1'b1;
      upd_v <= 6'h07;
      @(posedge clk_i);
      upd <= 1'b0;
      rdc("hw update", SLCR_IDX_TX_A, 16'h0007);
      chk("tx on", {31'h0, tx_en}, 32'h1);
      chk("cm on", {31'h0, ana.transmit_common_mode_enable}, 32'h1);
      for (int r = 0; r < 4; r++) begin
         wr(SLCR_IDX_TX_A, {11'h000, r[1:0], 3'h7});
         ticks(n);
         chk("baud ticks", n, exp_n[r]);
      end
      wr(SLCR_IDX_TX_A, 16'h0027);
      ticks(n);
      chk("reset ticks", n, 0);
      chk("reset stops", {31'h0, tx_en}, 32'h0);
      chk("reset pin", {31'h0, tx_rst}, 32'h1);
      wr(SLCR_IDX_TX_A, 16'h0005);
      ticks(n);
      chk("data blocked", n, 0);
      wr(SLCR_IDX_TX_A, 16'h0000);
      settle();
      chk("tx off", {31'h0, tx_en}, 32'h0);
      chk("cm off", {31'h0, ana.transmit_common_mode_enable}, 32'h0);
      wr(SLCR_IDX_TX_A, 16'h0007);
      txw <= 20'h12345;
      wr(SLCR_IDX_TX_C, 16'h1700);
      settle();
      chk("tx flipped", {12'h0, txw_o}, {12'h0, ~20'h12345});
      chk("boost", {28'h0, ana.transmit_boost_active, ana.transmit_boost_level}, 32'hB);
      wr(SLCR_IDX_TX_C, 16'h0000);
      settle();
      chk("tx straight", {12'h0, txw_o}, 32'h12345);
   endtask : t_tx
   task automatic t_detect;
      logic [15:0] q;
      logic e;
      int n;
      slow <= 1'b1;
      wr(SLCR_IDX_IRQ_ST, 16'h0003);
      wr(SLCR_IDX_TX_C, 16'h0080);
      #1;
      chk("request set", {31'h0, det_req}, 32'h1);
      n = 0;
      q = 16'h0000;
      while (q[1] !== 1'b1 && n < 30) begin
         wb(1'b0, SLCR_IDX_LANE_ST, 16'h0000, q, e);
         n++;
      end
      wr(SLCR_IDX_TX_C, 16'h0000);
      chk("ack seen", {31'h0, q[1]}, 32'h1);
      rdc("detect event", SLCR_IDX_IRQ_ST, 16'h0002);
      chk("irq masked", {31'h0, irq}, 32'h0);
      chk("request clear", {31'h0, det_req}, 32'h0);
   endtask : t_detect
   // ----------
   // Run control
   // ----------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_regs();
      t_rx();
      t_loss();
      t_tx();
      t_detect();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end
endmodule : slcr_lane_regs_tb
bind slcr_lane_regs slcr_lane_props u_props (.*);
